// ==== bench/panel_model.sv ====
// Behavioural model of the two panels on the far side of the links
`timescale 1ns/1ps
`default_nettype none
module panel_model (
    input wire logic clk,
    output logic te0_pin,
    output logic te1_pin,
    output logic lp_tx_busy
);
    initial begin
        te0_pin = 1'b0;
        te1_pin = 1'b0;
        lp_tx_busy = 1'b0;
    end

    // Each panel set in the mask raises its tearing pulse after the same chosen delay
    task automatic te_pulse(input logic [1:0] m, input int dly);
        repeat (dly) @(posedge clk);
        te0_pin <= m[0];
        te1_pin <= m[1];
        repeat (10) @(posedge clk);
        te0_pin <= 1'b0;
        te1_pin <= 1'b0;
        repeat (10) @(posedge clk);
    endtask

    // Low-power transmit flag, driven to the given value on the next clock and held there
    task automatic lp_msg(input logic v);
        @(posedge clk);
        lp_tx_busy <= v;
    endtask
endmodule
`default_nettype wire

// ==== bench/tb_dual_link_sync.sv ====
// Self-checking testbench for the dual-link port synchronisation block
`timescale 1ns/1ps
`default_nettype none
module tb_dual_link_sync;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic link_clk = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [3:0] sel = 4'hF;
    logic [31:0] dat = 32'h0;
    logic [31:0] dat_o;
    logic ack;
    logic te0, te1, lp;
    logic [11:0] tw = 12'h000;
    logic [11:0] w0, s0, w1, s1;
    logic tg0, tg1, f0, f1, cc0, cc1, err;
    int fails = 0;
    int checked = 0;
    int cycles = 0;
    logic [31:0] rd_q[$];
    logic [1:0] fs_q[$];
    logic [31:0] c0[6] = '{32'h0, 32'h1, 32'h101, 32'h2, 32'h3, 32'h3};
    logic [31:0] c1[6] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h103, 32'h3};
    logic [31:0] st[6] = '{32'h11, 32'h22, 32'h122, 32'h118, 32'h44, 32'h144};
    logic [7:0] fa[5] = '{8'h03, 8'h00, 8'h11, 8'h21, 8'h42};
    logic [1:0] ft[5] = '{2'h1, 2'h2, 2'h3, 2'h3, 2'h3};
    logic [7:0] fb[5] = '{8'h00, 8'h00, 8'h10, 8'h20, 8'h41};
    logic [1:0] fe[5] = '{2'h0, 2'h3, 2'h1, 2'h3, 2'h3};
    logic [7:0] ov;
    logic [1:0] fs_e;
    logic lpv;

    always #4 clk = ~clk;
    initial #3 forever #80 link_clk = ~link_clk;

    dual_link_sync dut_u (.clk(clk), .rst(rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .link_clk(link_clk), .te0_pin(te0), .te1_pin(te1),
        .total_width(tw), .lp_tx_busy(lp), .link0_width(w0),
        .link0_start(s0), .link1_width(w1), .link1_start(s1),
        .tg0_run(tg0), .tg1_run(tg1), .frame0_start(f0),
        .frame1_start(f1), .cont_clk0(cc0), .cont_clk1(cc1),
        .cfg_error(err));

    panel_model panel_u (.clk(clk), .te0_pin(te0), .te1_pin(te1),
        .lp_tx_busy(lp));

    task automatic give_verdict();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] s);
        checked++;
        if (e !== s) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask

    // One classic cycle; a read notes its expected data for the monitor
    task automatic wb(input logic w, input logic [3:0] a,
                      input logic [31:0] d, input logic [31:0] e);
        @(posedge clk);
        if (!w) rd_q.push_back(e);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        // An ack from the slave ends this wait, or else the bench timeout
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic lw(input int k);
        repeat (k * 20) @(posedge clk);
    endtask

    // Compares every read answer and every frame start against the notes
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            fails++;
            give_verdict();
        end
        if (ack === 1'b1 && we === 1'b0) begin
            chk("read data", rd_q.pop_front(), dat_o);
        end
        if (f0 === 1'b1 || f1 === 1'b1) begin
            fs_e = fs_q.size() ? fs_q.pop_front() : 2'h0;
            chk("frame start", 32'(fs_e), 32'({f1, f0}));
        end
    end

    initial begin
        void'($urandom(32'h7BF4BB17));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        wb(0, port_sync_pkg::OFF_SYNC0, 32'h0, port_sync_pkg::SYNC_RESET);
        wb(0, port_sync_pkg::OFF_SYNC1, 32'h0, port_sync_pkg::SYNC_RESET);
        wb(0, port_sync_pkg::OFF_FRAME, 32'h0, port_sync_pkg::FRAME_RESET);
        wb(1, 4'h1, 32'hFFFF_FFFF, 32'h0);
        wb(0, 4'h1, 32'h0, 32'h0);
        chk("cont clock", 32'h0, 32'({cc1, cc0}));
        for (int i = 0; i < 6; i++) begin
            lpv = 1'($urandom);
            panel_u.lp_msg(lpv);
            wb(1, port_sync_pkg::OFF_SYNC0, c0[i], 32'h0);
            wb(1, port_sync_pkg::OFF_SYNC1, c1[i], 32'h0);
            repeat (4) @(posedge clk);
            wb(0, port_sync_pkg::OFF_STATUS, 32'h0,
               st[i] | (32'(lpv) << 11));
            chk("config error", 32'(st[i][8]), 32'(err));
        end
        tw <= 12'($urandom_range(12'h7FF, 12'h100));
        ov = 8'($urandom_range(8'hFF, 8'h01));
        wb(1, port_sync_pkg::OFF_SYNC1, 32'h0, 32'h0);
        wb(1, port_sync_pkg::OFF_SYNC0, 32'h1, 32'h0);
        wb(1, port_sync_pkg::OFF_FRAME, 32'(ov) << 8, 32'h0);
        repeat (6) @(posedge clk);
        chk("link0 width", 32'(tw) + 32'(ov), 32'(w0));
        chk("link1 width", 32'(tw) + 32'(ov), 32'(w1));
        chk("link0 start", 32'h0, 32'(s0));
        chk("link1 start", 32'(tw) - 32'(ov), 32'(s1));
        wb(1, port_sync_pkg::OFF_SYNC0, 32'h30, 32'h0);
        lw(3);
        chk("leader alone", 32'hA, 32'({tg0, tg1, cc0, cc1}));
        chk("unsplit width", 32'(tw), 32'(w1));
        wb(1, port_sync_pkg::OFF_SYNC1, 32'h133, 32'h0);
        lw(3);
        chk("both running", 32'hF, 32'({tg0, tg1, cc0, cc1}));
        wb(1, port_sync_pkg::OFF_SYNC0, 32'h0002_001F, 32'h0);
        wb(1, port_sync_pkg::OFF_SYNC1, 32'h0002_011F, 32'h0);
        lw(4);
        // Rows: both, TE wait, single update, forward, accumulate
        for (int i = 0; i < 5; i++) begin
            if (fb[i][1:0] == 2'h0 && fe[i] != 2'h0) fs_q.push_back(fe[i]);
            wb(1, port_sync_pkg::OFF_FRAME, 32'(fa[i]), 32'h0);
            lw(4);
            panel_u.te_pulse(ft[i], $urandom_range(0, 5));
            lw(4);
            if (fb[i][1:0] != 2'h0) fs_q.push_back(fe[i]);
            wb(1, port_sync_pkg::OFF_FRAME, 32'(fb[i]), 32'h0);
            lw(4);
        end
        chk("frames missing", 32'h0, 32'(fs_q.size()));
        give_verdict();
    end
endmodule
`default_nettype wire

// ==== design/dual_link_sync.sv ====
// Dual-link port synchronisation block with Wishbone registers
`timescale 1ns/1ps
`default_nettype none
module dual_link_sync #(
    parameter int HALF_W = 12
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [port_sync_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic link_clk,
    input wire logic te0_pin,
    input wire logic te1_pin,
    input wire logic [HALF_W-1:0] total_width,
    input wire logic lp_tx_busy,
    output logic [HALF_W-1:0] link0_width,
    output logic [HALF_W-1:0] link0_start,
    output logic [HALF_W-1:0] link1_width,
    output logic [HALF_W-1:0] link1_start,
    output logic tg0_run,
    output logic tg1_run,
    output logic frame0_start,
    output logic frame1_start,
    output logic cont_clk0,
    output logic cont_clk1,
    output logic cfg_error
);
    if (HALF_W < port_sync_pkg::OVERLAP_W + 1) begin : g_width_check
        $error("HALF_W too small for overlap field");
    end

    logic [31:0] sync0_r;
    logic [31:0] sync1_r;
    logic [31:0] frame_r;
    logic [1:0] req_pulse;
    logic [31:0] eff1;
    port_sync_pkg::link_cfg_type cfg0;
    port_sync_pkg::link_cfg_type cfg1;
    logic mirror;
    logic bad_pipe;
    logic bad_dual;
    logic wr;
    logic [31:0] rd_nxt;
    logic ack_r;
    logic busy0;
    logic busy1;
    logic lp_busy_s;

    // Bus slave: one wait state, ack dropped after one cycle
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_r;
    assign wb_ack_o = ack_r;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] sel);
        for (int i = 0; i < 4; i++) begin
            merge[8*i +: 8] = sel[i] ? nw[8*i +: 8] : old[8*i +: 8];
        end
    endfunction

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync0_r <= port_sync_pkg::SYNC_RESET;
            sync1_r <= port_sync_pkg::SYNC_RESET;
            frame_r <= port_sync_pkg::FRAME_RESET;
        end else if (wr) begin
            case (wb_adr_i)
                port_sync_pkg::OFF_SYNC0:
                    sync0_r <= merge(sync0_r, wb_dat_i, wb_sel_i);
                port_sync_pkg::OFF_SYNC1:
                    sync1_r <= merge(sync1_r, wb_dat_i, wb_sel_i);
                port_sync_pkg::OFF_FRAME: begin
                    frame_r <= merge(frame_r, wb_dat_i, wb_sel_i);
                    // Request bits are write-one pulses, never stored
                    frame_r[port_sync_pkg::F_REQ0] <= 1'b0;
                    frame_r[port_sync_pkg::F_REQ1] <= 1'b0;
                end
                default: begin
                end
            endcase
        end
    end

    assign req_pulse[0] = wr && wb_sel_i[0] &&
        (wb_adr_i == port_sync_pkg::OFF_FRAME) &&
        wb_dat_i[port_sync_pkg::F_REQ0];
    assign req_pulse[1] = wr && wb_sel_i[0] &&
        (wb_adr_i == port_sync_pkg::OFF_FRAME) &&
        wb_dat_i[port_sync_pkg::F_REQ1];

    // Mode decode
    assign cfg0 = port_sync_pkg::decode_cfg(
        sync0_r[port_sync_pkg::F_DUAL_PIPE],
        sync0_r[port_sync_pkg::F_PORT_SYNC]);
    // Primary port sync without dual pipe mirrors into transcoder 1
    assign mirror = (cfg0 == port_sync_pkg::CFG_SINGLE_PIPE);
    assign eff1 = mirror ? sync0_r : sync1_r;
    assign cfg1 = port_sync_pkg::decode_cfg(
        eff1[port_sync_pkg::F_DUAL_PIPE],
        eff1[port_sync_pkg::F_PORT_SYNC]);

    // Single pipe only from first pipe
    assign bad_pipe = mirror &&
        (sync0_r[port_sync_pkg::F_PIPE_SEL +: port_sync_pkg::PIPE_W] !=
         port_sync_pkg::FIRST_PIPE);
    assign bad_dual = (cfg0 == port_sync_pkg::CFG_DUAL_PIPE) &&
        (cfg1 == port_sync_pkg::CFG_DUAL_PIPE) &&
        (sync0_r[port_sync_pkg::F_PIPE_SEL +: port_sync_pkg::PIPE_W] ==
         sync1_r[port_sync_pkg::F_PIPE_SEL +: port_sync_pkg::PIPE_W]);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_error <= 1'b0;
        end else begin
            cfg_error <= (cfg0 == port_sync_pkg::CFG_INVALID) ||
                (cfg1 == port_sync_pkg::CFG_INVALID) || bad_pipe ||
                bad_dual;
        end
    end

    always_comb begin
        rd_nxt = 32'h0000_0000;
        case (wb_adr_i)
            port_sync_pkg::OFF_SYNC0: rd_nxt = sync0_r;
            port_sync_pkg::OFF_SYNC1: rd_nxt = sync1_r;
            port_sync_pkg::OFF_FRAME: rd_nxt = frame_r;
            port_sync_pkg::OFF_STATUS: begin
                rd_nxt[3:0] = cfg0;
                rd_nxt[7:4] = cfg1;
                rd_nxt[8] = cfg_error;
                rd_nxt[9] = busy0;
                rd_nxt[10] = busy1;
                rd_nxt[11] = lp_busy_s;
            end
            default: rd_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_cyc_i && wb_stb_i && !ack_r) begin
            wb_dat_o <= rd_nxt;
        end
    end

    // Link clock, TE pins and LP status are sampled twice; edges found after
    logic [2:0] lclk_s;
    logic [2:0] te0_s;
    logic [2:0] te1_s;
    logic [1:0] lp_s;
    logic line_tick;
    logic te0_ev;
    logic te1_ev;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lclk_s <= 3'h0;
            te0_s <= 3'h0;
            te1_s <= 3'h0;
            lp_s <= 2'h0;
        end else begin
            lclk_s <= {lclk_s[1:0], link_clk};
            te0_s <= {te0_s[1:0], te0_pin};
            te1_s <= {te1_s[1:0], te1_pin};
            lp_s <= {lp_s[0], lp_tx_busy};
        end
    end
    assign lp_busy_s = lp_s[1];
    // One shared tick drives both gates, so no crossing between them
    assign line_tick = lclk_s[1] && !lclk_s[2];
    assign te0_ev = te0_s[1] && !te0_s[2];
    assign te1_ev = te1_s[1] && !te1_s[2];

    // Frame request routing: forward copies a request across
    logic fwd;
    logic accum;
    logic single;
    logic [1:0] req_in;
    logic [1:0] acc_r;
    logic [1:0] gate_req;
    logic synced0;
    logic synced1;
    logic [31:0] frame_eff;

    // Attributes written along with a request already apply to it
    assign frame_eff = (wr && (wb_adr_i == port_sync_pkg::OFF_FRAME)) ?
        merge(frame_r, wb_dat_i, wb_sel_i) : frame_r;
    assign fwd = frame_eff[port_sync_pkg::F_FORWARD];
    assign accum = frame_eff[port_sync_pkg::F_ACCUM];
    assign single = frame_eff[port_sync_pkg::F_SINGLE];
    assign req_in[0] = req_pulse[0] || (fwd && req_pulse[1]);
    assign req_in[1] = req_pulse[1] || (fwd && req_pulse[0]);

    // Accumulate holds requests until both pipes have asked
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc_r <= 2'h0;
        end else if (!accum || (&(acc_r | req_in))) begin
            acc_r <= 2'h0;
        end else begin
            acc_r <= acc_r | req_in;
        end
    end
    assign gate_req = !accum ? req_in :
        ((&(acc_r | req_in)) ? 2'h3 : 2'h0);

    // Cross-waiting only in command mode with dual-pipe sync
    assign synced0 = (cfg0 == port_sync_pkg::CFG_DUAL_PIPE) &&
        sync0_r[port_sync_pkg::F_CMD_MODE];
    assign synced1 = (cfg1 == port_sync_pkg::CFG_DUAL_PIPE) &&
        eff1[port_sync_pkg::F_CMD_MODE];

    sync_pair_if pair ();

    frame_gate gate0 (
        .clk(clk),
        .rst(rst),
        .line_tick(line_tick),
        .te_event(te0_ev),
        .te_gate(sync0_r[port_sync_pkg::F_TE_GATE]),
        .synced(synced0),
        .single_update(single),
        .vblank_lines(sync0_r[port_sync_pkg::F_VBLANK +:
            port_sync_pkg::VBLANK_W]),
        .request(gate_req[0]),
        .remote_ready(pair.ready1),
        .local_ready(pair.ready0),
        .frame_start(pair.start0),
        .busy(busy0)
    );

    frame_gate gate1 (
        .clk(clk),
        .rst(rst),
        .line_tick(line_tick),
        .te_event(te1_ev),
        .te_gate(eff1[port_sync_pkg::F_TE_GATE]),
        .synced(synced1),
        .single_update(single),
        .vblank_lines(eff1[port_sync_pkg::F_VBLANK +:
            port_sync_pkg::VBLANK_W]),
        .request(gate_req[1]),
        .remote_ready(pair.ready0),
        .local_ready(pair.ready1),
        .frame_start(pair.start1),
        .busy(busy1)
    );

    // Timing generators: a synced port waits for the running one
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tg0_run <= 1'b0;
            tg1_run <= 1'b0;
        end else begin
            if (!sync0_r[port_sync_pkg::F_TG_EN]) begin
                tg0_run <= 1'b0;
            end else if (!tg0_run && (!sync0_r[port_sync_pkg::F_PORT_SYNC]
                    || !tg1_run || line_tick)) begin
                tg0_run <= 1'b1;
            end
            if (!eff1[port_sync_pkg::F_TG_EN]) begin
                tg1_run <= 1'b0;
            end else if (!tg1_run && (!eff1[port_sync_pkg::F_PORT_SYNC]
                    || !tg0_run || line_tick)) begin
                tg1_run <= 1'b1;
            end
        end
    end

    // Registered frame starts for the links
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            frame0_start <= 1'b0;
            frame1_start <= 1'b0;
        end else begin
            frame0_start <= pair.start0;
            frame1_start <= pair.start1;
        end
    end

    // Continuous clock held low-power until software sets it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cont_clk0 <= 1'b0;
            cont_clk1 <= 1'b0;
        end else begin
            cont_clk0 <= sync0_r[port_sync_pkg::F_CONT_CLK];
            cont_clk1 <= eff1[port_sync_pkg::F_CONT_CLK];
        end
    end

    // Half image plus overlap per link when mirroring; hardware adds overlap, otherwise total_width alone
    logic [HALF_W-1:0] ovl;
    assign ovl = HALF_W'(frame_r[port_sync_pkg::F_OVERLAP +:
        port_sync_pkg::OVERLAP_W]);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            link0_width <= '0;
            link0_start <= '0;
            link1_width <= '0;
            link1_start <= '0;
        end else if (mirror) begin
            link0_width <= total_width + ovl;
            link0_start <= '0;
            link1_width <= total_width + ovl;
            link1_start <= total_width - ovl;
        end else begin
            link0_width <= total_width;
            link0_start <= '0;
            link1_width <= total_width;
            link1_start <= '0;
        end
    end

    mirror_dp_a: assert property (@(posedge clk)
        disable iff (rst) sync0_r[port_sync_pkg::F_DUAL_PIPE] |-> !mirror)
        else $error("mirroring active with dual pipe sync");
    invalid_cfg_a: assert property (@(posedge clk)
        disable iff (rst) (sync0_r[1:0] == 2'b10) |=> cfg_error)
        else $error("invalid sync setting not flagged");
    pipe_only_a_a: assert property (@(posedge clk)
        disable iff (rst) (mirror && sync0_r[9:8] != 2'h0) |=> cfg_error)
        else $error("single pipe from wrong pipe not flagged");
    overlap_add_a: assert property (@(posedge clk)
        disable iff (rst)
        $stable(total_width) && $stable(frame_r) && mirror && $past(mirror)
        |-> link1_width == total_width + ovl)
        else $error("link width lacks overlap");
    both_start_a: assert property (@(posedge clk)
        disable iff (rst)
        (pair.start0 && synced0 && !single) |-> pair.ready1)
        else $error("frame started before remote ready");
    forward_req_a: assert property (@(posedge clk)
        disable iff (rst)
        (fwd && !accum && req_pulse[0]) |=> busy1 || frame1_start)
        else $error("request not forwarded");
    cont_clk_a: assert property (@(posedge clk)
        disable iff (rst)
        !sync0_r[port_sync_pkg::F_CONT_CLK] [*2] |-> !cont_clk0)
        else $error("continuous clock without software setting");
    accum_hold_a: assert property (@(posedge clk)
        disable iff (rst) (accum && gate_req == 2'h1) |-> 1'b0)
        else $error("accumulated request released alone");
    tick_edge_a: assert property (@(posedge clk)
        disable iff (rst) line_tick |=> !line_tick)
        else $error("link tick longer than one cycle");
    late_attach_a: assert property (@(posedge clk)
        disable iff (rst) (tg0_run && !tg1_run && !line_tick &&
        eff1[port_sync_pkg::F_PORT_SYNC]) |=> !tg1_run)
        else $error("synced timing generator started off a link tick");
    bus_ack_a: assert property (@(posedge clk) disable iff (rst)
        ack_r |=> !ack_r)
        else $error("ack held for two cycles");

    synced_frame_c: cover property (@(posedge clk) disable iff (rst)
        pair.start0 && pair.start1 && synced0);
    single_update_c: cover property (@(posedge clk) disable iff (rst)
        pair.start0 && single && !pair.start1);
    mirror_run_c: cover property (@(posedge clk) disable iff (rst)
        mirror && tg1_run);
endmodule
`default_nettype wire

// ==== design/frame_gate.sv ====
// Per-transcoder command-mode frame start gate
`timescale 1ns/1ps
`default_nettype none
module frame_gate (
    input wire logic clk,
    input wire logic rst,
    input wire logic line_tick,
    input wire logic te_event,
    input wire logic te_gate,
    input wire logic synced,
    input wire logic single_update,
    input wire logic [port_sync_pkg::VBLANK_W-1:0] vblank_lines,
    input wire logic request,
    input wire logic remote_ready,
    output logic local_ready,
    output logic frame_start,
    output logic busy
);
    logic pend_r;
    logic te_r;
    logic [port_sync_pkg::VBLANK_W-1:0] vb_cnt_r;
    logic vb_met;

    assign vb_met = (vb_cnt_r >= vblank_lines);
    // Own vblank and TE both satisfied
    assign local_ready = pend_r && vb_met && (te_r || !te_gate);
    // Wait on remote when synced, unless single-panel update
    assign frame_start = local_ready &&
        (!synced || single_update || remote_ready);
    assign busy = pend_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pend_r <= 1'b0;
        end else if (request) begin
            pend_r <= 1'b1;
        end else if (frame_start) begin
            pend_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            te_r <= 1'b0;
        end else if (te_event) begin
            te_r <= 1'b1;
        end else if (frame_start) begin
            te_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            vb_cnt_r <= '0;
        end else if (frame_start) begin
            vb_cnt_r <= '0;
        end else if (line_tick && !vb_met) begin
            vb_cnt_r <= vb_cnt_r + 1'b1;
        end
    end

    start_needs_ready_a: assert property (@(posedge clk)
        disable iff (rst) frame_start |-> pend_r && vb_met)
        else $error("frame start without pending request and vblank");
    te_gating_a: assert property (@(posedge clk)
        disable iff (rst) (frame_start && te_gate) |-> te_r)
        else $error("frame start before tearing event");
endmodule
`default_nettype wire

// ==== design/port_sync_pkg.sv ====
// Constants and types shared by the dual-link port synchronisation block
package port_sync_pkg;
    localparam int ADDR_W = 4;
    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_SYNC0 = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_SYNC1 = 4'h4;
    localparam logic [ADDR_W-1:0] OFF_FRAME = 4'h8;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 4'hC;
    // Per-transcoder control fields (same bit positions in sync0 and sync1)
    localparam int F_PORT_SYNC = 0;
    localparam int F_DUAL_PIPE = 1;
    localparam int F_TE_GATE = 2;
    localparam int F_CMD_MODE = 3;
    localparam int F_TG_EN = 4;
    localparam int F_CONT_CLK = 5;
    localparam int F_PIPE_SEL = 8;
    localparam int PIPE_W = 2;
    localparam int F_VBLANK = 16;
    localparam int VBLANK_W = 12;
    // Frame update control fields
    localparam int F_REQ0 = 0;
    localparam int F_REQ1 = 1;
    localparam int F_SINGLE = 4;
    localparam int F_FORWARD = 5;
    localparam int F_ACCUM = 6;
    localparam int F_OVERLAP = 8;
    localparam int OVERLAP_W = 8;
    localparam logic [31:0] SYNC_RESET = 32'h0000_0000;
    localparam logic [31:0] FRAME_RESET = 32'h0000_0000;
    localparam logic [PIPE_W-1:0] FIRST_PIPE = 2'h0;
    localparam int LINK_CLK_MIN_CYCLES = 4;

    typedef enum logic [3:0] {
        CFG_INDEPENDENT = 4'h1,
        CFG_SINGLE_PIPE = 4'h2,
        CFG_DUAL_PIPE = 4'h4,
        CFG_INVALID = 4'h8
    } link_cfg_type;

    function automatic link_cfg_type decode_cfg(input logic dual,
                                                input logic sync);
        case ({dual, sync})
            2'b00: decode_cfg = CFG_INDEPENDENT;
            2'b01: decode_cfg = CFG_SINGLE_PIPE;
            2'b11: decode_cfg = CFG_DUAL_PIPE;
            default: decode_cfg = CFG_INVALID;
        endcase
    endfunction
endpackage

// ==== design/sync_pair_if.sv ====
// Handshake bundle between the two transcoder frame gates
`timescale 1ns/1ps
`default_nettype none
interface sync_pair_if;
    logic ready0;
    logic ready1;
    logic start0;
    logic start1;
    modport gate0 (output ready0, output start0, input ready1, input start1);
    modport gate1 (output ready1, output start1, input ready0, input start0);
    modport watch (input ready0, input ready1, input start0, input start1);
endinterface
`default_nettype wire
